/* core/sdc_map.svh */
// Purpose: Offsets, field positions, codes and reset values of the
//          segment descriptor checker.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SDC_OFS_DLO 12'h000
`define SDC_OFS_DHI 12'h004
`define SDC_OFS_CTRL 12'h008
`define SDC_OFS_STAT 12'h00C
`define SDC_OFS_DEST 12'h010

// ----------------------------------------------------------------
// Attribute word fields (upper descriptor word); selector field of the lower word
// ----------------------------------------------------------------
`define SDC_B_PRES 15
`define SDC_B_DPLH 14
`define SDC_B_DPLL 13
`define SDC_B_CLASS 12
`define SDC_B_TYPH 11
`define SDC_B_TYPL 8
`define SDC_TB_EXE 3
`define SDC_TB_CE 2
`define SDC_TB_RW 1
`define SDC_TB_ACC 0
`define SDC_B_SELH 31
`define SDC_B_SELL 16

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SDC_C_CPLH 1
`define SDC_C_CPLL 0
`define SDC_C_RPLH 3
`define SDC_C_RPLL 2
`define SDC_C_OPH 5
`define SDC_C_OPL 4
`define SDC_C_GO 8

// ----------------------------------------------------------------
// System type codes (class bit zero)
// ----------------------------------------------------------------
`define SDC_T_TSS16A 4'h1
`define SDC_T_LDT 4'h2
`define SDC_T_TSS16B 4'h3
`define SDC_T_CALL16 4'h4
`define SDC_T_TASKG 4'h5
`define SDC_T_INT16 4'h6
`define SDC_T_TRAP16 4'h7
`define SDC_T_TSS32A 4'h9
`define SDC_T_TSS32B 4'hB
`define SDC_T_CALL32 4'hC
`define SDC_T_INT32 4'hE
`define SDC_T_TRAP32 4'hF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDC_WORD_RST 32'h0000_0000
`define SDC_PL_RST 2'h0

`endif

/* core/sdc_pkg.sv */
// Purpose: Types shared by the segment descriptor checker.
// Assumes: Nothing beyond SystemVerilog enums.
// Notes:   Kind codes read back in declaration order, from zero.
package sdc_pkg;

  // Descriptor classification
  typedef enum logic [3:0] {
    K_DATA, K_CODE, K_TSS16_AVL, K_LDT, K_TSS16_BUSY, K_CALL16,
    K_TASK_GATE, K_INT16, K_TRAP16, K_TSS32_AVL, K_TSS32_BUSY,
    K_CALL32, K_INT32, K_TRAP32, K_RSVD
  } sdc_kind_t;

  // Requested check
  typedef enum logic [1:0] {OP_LOAD, OP_JUMP, OP_CALL, OP_NONE} sdc_op_t;

  // Checker sequence
  typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_WAIT, ST_FINISH} sdc_state_t;

endpackage

/* core/sdc_checker.sv */
// Purpose: Decode descriptor attribute words and check control transfers.
// Assumes: Partner returns the destination word on a req/ack handshake.
// Notes:   Registers on APB; all outputs registered.
// Operation
// [RQ1] Attribute bit 15 is the present flag; one means allocated.
// [RQ2] Loading a descriptor with present clear raises not-present fault.
// [RQ3] Bits 14:13 give descriptor privilege; 00 highest, 11 lowest.
// [RQ4] Bit 12 set means code/data segment, clear means system or gate.
// [RQ5] Type bits 11:8; bit 11 executable, bit 8 accessed.
// [RQ6] Bit 10 is conforming for class one, expand-down for class zero.
// [RQ7] Bit 9 is readable for class one, writable for class zero.
// [RQ8] System types 0001/0010/0011: 16-bit free TASK_STATE_SEGMENT, local table, busy TASK_STATE_SEGMENT.
// [RQ9] System types 0100..0111: call gate, task gate, interrupt, trap (16-bit).
// [RQ10] System 1001/1011 32-bit TASK_STATE_SEGMENT; 1100/1110/1111 32-bit gates.
// [RQ11] Application types 0000..0111 are data: write, expand-down, accessed.
// [RQ12] Application types 1000..1111 are code: read, conforming, accessed.
// [RQ13] Exactly four gate kinds: call, trap, interrupt and task gates.
// [RQ14] Call/jump through a call gate fetches destination by gate selector.
// [RQ15] Larger of current and requested privilege must not exceed gate's.
// [RQ16] Jump through call gate: destination privilege equals current.
// [RQ17] Call through call gate: destination privilege at most current.
// [RQ18] Conforming code reached from lower privilege without any gate.
// [RQ19] Every descriptor is an eight-byte entry of two words.
// [RQ20] Reserved system types 0000/1000/1010/1101 raise a protection fault.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "sdc_map.svh"

module sdc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fetch_req,
  output logic [15:0] fetch_sel,
  input wire logic fetch_ack,
  input wire logic [31:0] fetch_word,
  output logic np_fault,
  output logic gp_fault,
  output logic check_done
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // Classification helper
  // ----------------------------------------------------------------
  // Application words split on the executable bit; system words by code
  function automatic sdc_kind_t kind_of(input logic app, input logic [3:0] ty);
    if (app) begin
      return ty[`SDC_TB_EXE] ? K_CODE : K_DATA; // RQ11 RQ12
    end
    unique case (ty)
      `SDC_T_TSS16A: return K_TSS16_AVL; // RQ8
      `SDC_T_LDT: return K_LDT; // RQ8
      `SDC_T_TSS16B: return K_TSS16_BUSY; // RQ8
      `SDC_T_CALL16: return K_CALL16; // RQ9
      `SDC_T_TASKG: return K_TASK_GATE; // RQ9
      `SDC_T_INT16: return K_INT16; // RQ9
      `SDC_T_TRAP16: return K_TRAP16; // RQ9
      `SDC_T_TSS32A: return K_TSS32_AVL; // RQ10
      `SDC_T_TSS32B: return K_TSS32_BUSY; // RQ10
      `SDC_T_CALL32: return K_CALL32; // RQ10
      `SDC_T_INT32: return K_INT32; // RQ10
      `SDC_T_TRAP32: return K_TRAP32; // RQ10
      default: return K_RSVD; // RQ20
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] dlo_r;
  logic [31:0] dhi_r;
  logic [31:0] dest_r;
  logic [1:0] cpl_r;
  logic [1:0] rpl_r;
  sdc_op_t op_r;
  sdc_state_t state_r;
  sdc_state_t state_nxt;
  logic done_r;
  logic granted_r;
  logic np_r;
  logic gp_r;
  logic via_gate_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic fetch_req_r;
  logic [15:0] fetch_sel_r;
  logic np_fault_r;
  logic gp_fault_r;
  logic check_done_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Descriptor decode
  // ----------------------------------------------------------------
  // Held descriptor fields
  wire d_pres = dhi_r[`SDC_B_PRES]; // RQ1
  wire [1:0] d_dpl = dhi_r[`SDC_B_DPLH:`SDC_B_DPLL]; // RQ3
  wire d_app = dhi_r[`SDC_B_CLASS]; // RQ4
  wire [3:0] d_type = dhi_r[`SDC_B_TYPH:`SDC_B_TYPL]; // RQ5
  sdc_kind_t d_kind;
  assign d_kind = kind_of(d_app, d_type);
  wire d_code = d_kind == K_CODE;
  wire d_conf = d_code & d_type[`SDC_TB_CE]; // RQ6
  wire d_cgate = (d_kind == K_CALL16) | (d_kind == K_CALL32);
  wire d_gate = d_cgate | (d_kind == K_TASK_GATE) | (d_kind == K_INT16) |
                (d_kind == K_INT32) | (d_kind == K_TRAP16) | (d_kind == K_TRAP32); // RQ13

  // Permission flags, meaning depends on the class bit
  wire f_exe = d_type[`SDC_TB_EXE]; // RQ5
  wire f_acc = d_type[`SDC_TB_ACC]; // RQ5
  wire f_conf = d_app & d_type[`SDC_TB_CE]; // RQ6
  // Expand-down applies to system words and to application data alike
  wire f_expd = (~d_app | ~f_exe) & d_type[`SDC_TB_CE]; // RQ6 RQ11
  wire f_read = d_app & (~f_exe | d_type[`SDC_TB_RW]); // RQ7
  wire f_write = ~d_app ? d_type[`SDC_TB_RW] : (~f_exe & d_type[`SDC_TB_RW]); // RQ7 RQ11
  wire f_busy = (d_kind == K_TSS16_BUSY) | (d_kind == K_TSS32_BUSY);

  // Fetched destination fields
  // Only the attribute word of the destination is fetched; base and limit
  // checks belong to the segment load path and are not repeated here.
  wire t_pres = dest_r[`SDC_B_PRES]; // RQ1
  wire [1:0] t_dpl = dest_r[`SDC_B_DPLH:`SDC_B_DPLL]; // RQ3
  wire t_code = dest_r[`SDC_B_CLASS] & dest_r[`SDC_B_TYPH]; // RQ4 RQ5

  // ----------------------------------------------------------------
  // First-stage verdict on the held descriptor
  // ----------------------------------------------------------------
  // Faults are ranked: a protection fault hides a not-present fault, so a
  // reserved descriptor or over-privileged call gate never reports absence first.
  wire [1:0] eff_pl = (cpl_r > rpl_r) ? cpl_r : rpl_r; // RQ15
  wire xfer = (op_r == OP_JUMP) | (op_r == OP_CALL);
  wire e_rsvd = (d_kind == K_RSVD) & (op_r != OP_NONE); // RQ20
  wire e_gpriv = xfer & d_cgate & (eff_pl > d_dpl); // RQ15
  // Direct code target: conforming may be more privileged, else same level
  wire e_cpriv = d_conf ? (d_dpl > cpl_r) : (d_dpl != cpl_r); // RQ18
  wire e_badtgt = xfer & ~d_cgate & ~d_code;
  wire e_gp = e_rsvd | e_gpriv | e_badtgt | (xfer & d_code & d_pres & e_cpriv);
  wire e_np = ~e_gp & (op_r != OP_NONE) & ~d_pres; // RQ2
  wire e_fetch = xfer & d_cgate & ~e_gp & ~e_np; // RQ14

  // ----------------------------------------------------------------
  // Second-stage verdict on the destination code segment
  // ----------------------------------------------------------------
  // A jump keeps the level; a call may move inward only
  wire f_priv = (op_r == OP_JUMP) ? (t_dpl != cpl_r) : (t_dpl > cpl_r); // RQ16 RQ17
  wire f_gp = ~t_code | (t_pres & f_priv);
  wire f_np = ~f_gp & ~t_pres;

  // Completion and merged result
  wire fin = ((state_r == ST_EVAL) & ~e_fetch) | (state_r == ST_FINISH);
  wire r_gp = (state_r == ST_EVAL) ? e_gp : f_gp;
  wire r_np = (state_r == ST_EVAL) ? e_np : f_np;
  wire r_ok = ~r_gp & ~r_np & (op_r != OP_NONE);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // STAT is computed live from the held words, so the decode fields follow
  // a DHI write at once, while the verdict bits wait for a finished check.
  // Unmapped offsets answer with an error and read as zero; writes to the
  // read-only words are taken without error and have no effect.
  wire setup = psel & ~penable;
  wire acc_edge = psel & penable & pready_r;
  wire hit_dlo = paddr == `SDC_OFS_DLO;
  wire hit_dhi = paddr == `SDC_OFS_DHI;
  wire hit_ctrl = paddr == `SDC_OFS_CTRL;
  wire hit_stat = paddr == `SDC_OFS_STAT;
  wire hit_dest = paddr == `SDC_OFS_DEST;
  wire hit_any = hit_dlo | hit_dhi | hit_ctrl | hit_stat | hit_dest;
  // Writes are dropped while a check runs so its inputs stay stable
  wire wr_ok = acc_edge & pwrite & (state_r == ST_IDLE);
  wire go = wr_ok & hit_ctrl & pwdata[`SDC_C_GO];
  wire [31:0] ctrl_w = {26'h0, op_r, rpl_r, cpl_r};
  wire [31:0] stat_w = {6'h00, f_busy, f_acc, f_exe, f_expd, f_conf, f_write, f_read,
                        via_gate_r, gp_r, np_r, granted_r, done_r, state_r != ST_IDLE,
                        d_gate, d_kind, d_type, d_app, d_dpl, d_pres};
  wire [31:0] rd_w = hit_dlo ? dlo_r : hit_dhi ? dhi_r : hit_ctrl ? ctrl_w :
                     hit_stat ? stat_w : hit_dest ? dest_r : 32'h0000_0000;

  // APB answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `SDC_WORD_RST;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~hit_any;
      prdata_r <= (setup & ~pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // Descriptor words, two per eight-byte entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlo_r <= `SDC_WORD_RST;
      dhi_r <= `SDC_WORD_RST;
    end else begin
      if (wr_ok & hit_dlo) dlo_r <= pwdata; // RQ19
      if (wr_ok & hit_dhi) dhi_r <= pwdata; // RQ19
    end
  end

  // Check parameters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_r <= `SDC_PL_RST;
      rpl_r <= `SDC_PL_RST;
      op_r <= OP_LOAD;
    end else if (wr_ok & hit_ctrl) begin
      cpl_r <= pwdata[`SDC_C_CPLH:`SDC_C_CPLL];
      rpl_r <= pwdata[`SDC_C_RPLH:`SDC_C_RPLL];
      op_r <= sdc_op_t'(pwdata[`SDC_C_OPH:`SDC_C_OPL]);
    end
  end

  // ----------------------------------------------------------------
  // Check sequence
  // ----------------------------------------------------------------
  // EVAL judges the held descriptor; WAIT and FINISH follow only when a call
  // gate passes its own checks and the destination must be fetched.
  // Limitation: the fetch has no timeout; a partner that never acknowledges
  // leaves the checker busy until reset, with every register write dropped.
  // A start written while busy is ignored rather than queued, so the core
  // must wait for the done pulse before issuing the next check.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (go) state_nxt = ST_EVAL;
      ST_EVAL: state_nxt = e_fetch ? ST_WAIT : ST_IDLE;
      ST_WAIT: if (fetch_ack) state_nxt = ST_FINISH;
      ST_FINISH: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // Destination fetch handshake, request held until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_req_r <= 1'b0;
      fetch_sel_r <= 16'h0000;
      dest_r <= `SDC_WORD_RST;
    end else begin
      if (state_r == ST_EVAL && e_fetch) begin
        fetch_req_r <= 1'b1; // RQ14
        fetch_sel_r <= dlo_r[`SDC_B_SELH:`SDC_B_SELL]; // RQ14
      end else if (state_r == ST_WAIT && fetch_ack) begin
        fetch_req_r <= 1'b0;
        dest_r <= fetch_word;
      end
    end
  end

  // Sticky results; a new start clears them, completion sets them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      granted_r <= 1'b0;
      np_r <= 1'b0;
      gp_r <= 1'b0;
      via_gate_r <= 1'b0;
    end else if (go) begin
      done_r <= 1'b0;
      granted_r <= 1'b0;
      np_r <= 1'b0;
      gp_r <= 1'b0;
      via_gate_r <= 1'b0;
    end else if (fin) begin
      done_r <= 1'b1;
      granted_r <= r_ok;
      np_r <= r_np; // RQ2
      gp_r <= r_gp; // RQ15 RQ20
      via_gate_r <= state_r == ST_FINISH;
    end
  end

  // One-cycle fault and completion pulses toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_fault_r <= 1'b0;
      gp_fault_r <= 1'b0;
      check_done_r <= 1'b0;
    end else begin
      np_fault_r <= fin & r_np; // RQ2
      gp_fault_r <= fin & r_gp; // RQ20
      check_done_r <= fin;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fetch_req = fetch_req_r;
  assign fetch_sel = fetch_sel_r;
  assign np_fault = np_fault_r;
  assign gp_fault = gp_fault_r;
  assign check_done = check_done_r;

  // ----------------------------------------------------------------
  // Checks on the verdicts
  // ----------------------------------------------------------------
  sequence s_eval_gate_ok;
    state_r == ST_EVAL && xfer && d_cgate && d_pres && eff_pl <= d_dpl;
  endsequence

  sequence s_fetch_out;
    fetch_req_r && state_r == ST_WAIT;
  endsequence

  property p_np_load;
    state_r == ST_EVAL && op_r == OP_LOAD && !d_pres && d_kind != K_RSVD |=> np_fault && !gp_fault && np_r;
  endproperty
  a_np_load: assert property (p_np_load) else $error("absent segment load not faulted"); // RQ2

  property p_rsvd;
    state_r == ST_EVAL && !d_app && d_kind == K_RSVD && op_r != OP_NONE |=> gp_fault && !granted_r;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved system type accepted"); // RQ20

  property p_gate_priv;
    state_r == ST_EVAL && xfer && d_cgate && eff_pl > d_dpl |=> gp_fault && !fetch_req;
  endproperty
  a_gate_priv: assert property (p_gate_priv) else $error("gate privilege not enforced"); // RQ15

  property p_fetch_sel;
    s_eval_gate_ok ##1 s_fetch_out |-> fetch_sel == $past(dlo_r[31:16], 1);
  endproperty
  a_fetch_sel: assert property (p_fetch_sel) else $error("wrong destination selector"); // RQ14

  property p_gate_fetch;
    s_eval_gate_ok |=> s_fetch_out;
  endproperty
  a_gate_fetch: assert property (p_gate_fetch) else $error("gate did not fetch destination"); // RQ14

  property p_jump_eq;
    state_r == ST_FINISH && op_r == OP_JUMP && t_code && t_pres && t_dpl != cpl_r |=> gp_fault ##1 !gp_fault;
  endproperty
  a_jump_eq: assert property (p_jump_eq) else $error("jump to other level allowed"); // RQ16

  property p_call_le;
    state_r == ST_FINISH && op_r == OP_CALL && t_code && t_pres && t_dpl <= cpl_r
      |=> check_done && !gp_fault && granted_r && via_gate_r;
  endproperty
  a_call_le: assert property (p_call_le) else $error("legal gate call refused"); // RQ17

  property p_conform;
    state_r == ST_EVAL && op_r == OP_CALL && d_conf && d_pres && d_dpl <= cpl_r |=> granted_r && !via_gate_r;
  endproperty
  a_conform: assert property (p_conform) else $error("conforming call refused"); // RQ18

  property p_kind;
    state_r == ST_IDLE && d_app |-> d_kind == (dhi_r[11] ? K_CODE : K_DATA);
  endproperty
  a_kind: assert property (p_kind) else $error("application class wrong"); // RQ11 RQ12

  property p_dest_np;
    state_r == ST_FINISH && t_code && !t_pres |=> np_fault && !gp_fault && np_r;
  endproperty
  a_dest_np: assert property (p_dest_np) else $error("absent destination not faulted"); // RQ2

  property p_data_expd;
    d_app && !f_exe |-> f_expd == d_type[`SDC_TB_CE];
  endproperty
  a_data_expd: assert property (p_data_expd) else $error("data expand-down flag lost"); // RQ11

endmodule

/* verification/sdc_fetch_model.sv */
// Purpose: Model of the segment load logic that answers destination fetches.
// Assumes: One clock; acknowledge is a one-cycle pulse after a set delay.
// Notes:   Outside the acknowledge cycle the word shows its inverse,
//          so a checker that samples late sees a wrong value.
`timescale 1ns/1ns

module sdc_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_sel,
  output logic fetch_ack,
  output logic [31:0] fetch_word,
  input wire logic [7:0] delay,
  input wire logic [31:0] word
);
  logic ack_r;
  logic [7:0] cnt_r;

  // Wait delay cycles on a pending fetch, then hand over the upper word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (ack_r) begin
      ack_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (fetch_req) begin
      if (cnt_r == delay) begin
        ack_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // Word is only meaningful in the acknowledge cycle
  assign fetch_ack = ack_r;
  assign fetch_word = ack_r ? word : ~word;
endmodule

/* verification/sdc_checker_tb_top.sv */
// Purpose: Self-checking bench for the segment descriptor checker.
// Assumes: APB answers with one access cycle; results read from STAT.
// Notes:   Expected values come from the attribute fields, not the design.
`timescale 1ns/1ns
`include "sdc_map.svh"

module sdc_checker_tb_top;
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [15:0] SEL = 16'h5A3C;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, fetch_req, fetch_ack, np_fault, gp_fault, check_done;
  logic [15:0] fetch_sel;
  logic [31:0] fetch_word;
  logic [7:0] m_delay = 8'h00;
  logic [31:0] m_word = 32'h0000_0000;
  int n_errors = 0;
  int checked = 0;
  sdc_kind_t sys_tab [16] = '{K_RSVD, K_TSS16_AVL, K_LDT, K_TSS16_BUSY, K_CALL16, K_TASK_GATE, K_INT16,
    K_TRAP16, K_RSVD, K_TSS32_AVL, K_RSVD, K_TSS32_BUSY, K_CALL32, K_RSVD, K_INT32, K_TRAP32};

  always #50 pclk = ~pclk;

  sdc_checker dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_req(fetch_req), .fetch_sel(fetch_sel), .fetch_ack(fetch_ack), .fetch_word(fetch_word),
    .np_fault(np_fault), .gp_fault(gp_fault), .check_done(check_done));

  sdc_fetch_model part_u (.pclk(pclk), .presetn(presetn), .fetch_req(fetch_req), .fetch_sel(fetch_sel),
    .fetch_ack(fetch_ack), .fetch_word(fetch_word), .delay(m_delay), .word(m_word));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; an idle edge follows so psel is never set twice at once
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask

  function automatic logic [31:0] mk(input logic p, input logic [1:0] d, input logic c, input logic [3:0] t);
    return {16'hC3A5, p, d, c, t, 8'h7E};
  endfunction

  // Load a descriptor, start a check, watch the pulses and the fetch, read STAT
  task run(input logic [1:0] op, input logic [1:0] current_privilege, input logic [1:0] requested_privilege, input logic [31:0] dhi,
           input logic [31:0] dst, input logic [7:0] dly, input logic ef, input logic enp, input logic egp,
           output logic [31:0] st);
    logic seen;
    int n;
    m_word <= dst;
    m_delay <= dly;
    wr(`SDC_OFS_DLO, {SEL, 16'hFFFF});
    wr(`SDC_OFS_DHI, dhi);
    wr(`SDC_OFS_CTRL, {23'h000000, 1'b1, 2'b00, op, requested_privilege, current_privilege});
    seen = 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (fetch_req === 1'b1) begin
        seen = 1'b1;
        chk("fetch_sel", {16'h0000, SEL}, {16'h0000, fetch_sel});
      end
    end while (check_done !== 1'b1 && n < 64);
    if (n >= 64) begin
      n_errors++;
      summarize();
    end
    chk("np_fault", {31'h0, enp}, {31'h0, np_fault});
    chk("gp_fault", {31'h0, egp}, {31'h0, gp_fault});
    chk("fetch", {31'h0, ef}, {31'h0, seen});
    // Done comes two edges after the start edge; the write task spends one
    if (!ef) chk("latency", 32'h1, 32'(n));
    rd(`SDC_OFS_STAT, st);
    chk("granted", {31'h0, op != 2'd3 && !enp && !egp}, {31'h0, st[15]});
    if (ef) begin
      rd(`SDC_OFS_DEST, st);
      chk("dest", dst, st);
      rd(`SDC_OFS_STAT, st);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] st, ex, msk;
    logic e, c, p;
    logic [3:0] t;
    sdc_kind_t k;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped place, read-only STAT, read-write DLO
    for (int a = 0; a < 5; a++) begin
      rd(12'(a * 4), st);
      // A zero attribute word decodes as a reserved system type
      chk("reset_val", (a == 3) ? {20'h00000, K_RSVD, 8'h00} : 32'h0000_0000, st);
    end
    apb(1'b0, 12'h014, 32'h0000_0000, st, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0000_0000, st);
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, st, e);
    chk("slverr_wr", 32'h1, {31'h0, e});
    wr(`SDC_OFS_STAT, 32'hFFFF_FFFF);
    rd(`SDC_OFS_STAT, st);
    chk("stat_ro", {20'h00000, K_RSVD, 8'h00}, st);
    wr(`SDC_OFS_DLO, 32'hDEAD_BEEF);
    rd(`SDC_OFS_DLO, st);
    chk("dlo_rw", 32'hDEAD_BEEF, st);
    // Decode every class and type code, present and privilege varied
    for (int i = 0; i < 32; i++) begin
      c = i[4];
      t = i[3:0];
      p = i[0] ^ i[4];
      run(2'd3, 2'd0, 2'd0, mk(p, i[2:1], c, t), 32'h0, 8'd0, 1'b0, 1'b0, 1'b0, st);
      k = c ? (t[3] ? K_CODE : K_DATA) : sys_tab[t];
      ex = {18'h00001, 1'b0, (k inside {K_CALL16, K_TASK_GATE, K_INT16, K_TRAP16, K_CALL32, K_INT32, K_TRAP32}),
            k, t, c, i[2:1], p};
      ex[24] = t[0];
      ex[25] = (k == K_TSS16_BUSY) || (k == K_TSS32_BUSY);
      msk = 32'h0303_FFFF;
      if (c && t[3]) begin
        msk = msk | 32'h00A8_0000;
        ex[19] = t[1];
        ex[21] = t[2];
      end else begin
        msk = msk | 32'h0050_0000;
        ex[20] = t[1];
        ex[22] = t[2];
      end
      if (c) begin
        msk[23] = 1'b1;
        ex[23] = t[3];
      end
      chk("stat", ex & msk, st & msk);
    end
    // Transfers through call gates, with prompt and slow partner
    run(2'd2, 2'd2, 2'd1, mk(1, 2, 0, 4'h4), mk(1, 1, 1, 4'hA), 8'd0, 1, 0, 0, st);
    run(2'd1, 2'd2, 2'd1, mk(1, 2, 0, 4'h4), mk(1, 1, 1, 4'hA), 8'd4, 1, 0, 1, st);
    run(2'd1, 2'd2, 2'd2, mk(1, 2, 0, 4'h4), mk(1, 2, 1, 4'hB), 8'd7, 1, 0, 0, st);
    run(2'd2, 2'd3, 2'd0, mk(1, 2, 0, 4'h4), 32'h0, 8'd0, 0, 0, 1, st);
    run(2'd2, 2'd0, 2'd3, mk(1, 2, 0, 4'h4), 32'h0, 8'd0, 0, 0, 1, st);
    run(2'd2, 2'd3, 2'd3, mk(1, 3, 0, 4'hC), mk(0, 1, 1, 4'hA), 8'd2, 1, 1, 0, st);
    run(2'd2, 2'd1, 2'd0, mk(1, 3, 0, 4'hC), mk(1, 0, 1, 4'h2), 8'd1, 1, 0, 1, st);
    run(2'd2, 2'd3, 2'd3, mk(1, 3, 0, 4'hC), mk(1, 0, 1, 4'hE), 8'd3, 1, 0, 0, st);
    // Direct transfers to code, data and system descriptors
    run(2'd1, 2'd1, 2'd1, mk(1, 1, 1, 4'h8), 32'h0, 8'd0, 0, 0, 0, st);
    run(2'd2, 2'd3, 2'd0, mk(1, 0, 1, 4'hA), 32'h0, 8'd0, 0, 0, 1, st);
    run(2'd2, 2'd3, 2'd3, mk(1, 0, 1, 4'hC), 32'h0, 8'd0, 0, 0, 0, st);
    run(2'd1, 2'd0, 2'd0, mk(1, 0, 1, 4'h2), 32'h0, 8'd0, 0, 0, 1, st);
    run(2'd1, 2'd0, 2'd0, mk(1, 0, 0, 4'h9), 32'h0, 8'd0, 0, 0, 1, st);
    // Segment loads: present, absent, reserved system codes
    run(2'd0, 2'd0, 2'd0, mk(1, 3, 1, 4'h3), 32'h0, 8'd0, 0, 0, 0, st);
    run(2'd0, 2'd0, 2'd0, mk(0, 3, 1, 4'h3), 32'h0, 8'd0, 0, 1, 0, st);
    foreach (sys_tab[j]) begin
      if (sys_tab[j] == K_RSVD) run(2'd0, 2'd0, 2'd0, mk(j % 2, 0, 0, 4'(j)), 32'h0, 8'd0, 0, 0, 1, st);
    end
    summarize();
  end
endmodule
